// ===== remap_mux_pkg.sv
// Purpose: Shared constants and carriers for the alternate function remap mux
// Assumes: Five ports of sixteen bits; pin code is {port, bit} in one byte
// Notes: Register offsets are byte addresses on the plain register port

package remap_mux_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SIG = 74;
  localparam int NUM_PIN = 80;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] OFS_REMAP_ONE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_REMAP_TWO = 8'h1c;
  localparam logic [31:0] RST_REMAP_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_REMAP_TWO = 32'h0000_0000;
  localparam logic [31:0] MASK_REMAP_ONE = 32'h0001_8ffc;
  localparam logic [31:0] MASK_REMAP_TWO = 32'h07ff_007c;

  // ****************************************
  // Field positions, remap_config_reg_one
  // ****************************************
  localparam int F_SERIAL1_LOW = 2;
  localparam int F_SERIAL2 = 3;
  localparam int F_SERIAL3 = 4;
  localparam int F_ADV_TIMER1 = 6;
  localparam int F_TIMER2 = 8;
  localparam int F_TIMER3 = 10;
  localparam int F_MAIN_XTAL = 15;
  localparam int F_TIMER5_CH4 = 16;

  // ****************************************
  // Field positions, remap_config_reg_two
  // ****************************************
  localparam int F_ADV_TIMER8 = 2;
  localparam int F_ADV_TIMER9 = 3;
  localparam int F_ADV_TIMER10 = 5;
  localparam int F_SERIAL4 = 16;
  localparam int F_SERIAL5 = 18;
  localparam int F_SERIAL1_HIGH = 26;

  // ****************************************
  // Signal index bases
  // ****************************************
  localparam int B_TIM1 = 0;
  localparam int B_TIM2 = 9;
  localparam int B_TIM3 = 14;
  localparam int B_TIM5 = 18;
  localparam int B_TIM8 = 19;
  localparam int B_TIM9 = 28;
  localparam int B_TIM10 = 37;
  localparam int B_SER1 = 46;
  localparam int B_SER2 = 51;
  localparam int B_SER3 = 56;
  localparam int B_SER4 = 61;
  localparam int B_SER5 = 66;

  // ****************************************
  // Special pin codes
  // ****************************************
  localparam logic [7:0] PIN_NONE = 8'hff;
  localparam logic [7:0] PIN_LSI = 8'hfe;
  localparam logic [7:0] PIN_LIMIT = 8'h50;
  localparam int PIN_LS_XTAL_A = 8'h2e;
  localparam int PIN_LS_XTAL_B = 8'h2f;
  localparam int PIN_MAIN_XTAL_A = 8'h30;
  localparam int PIN_MAIN_XTAL_B = 8'h31;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [NUM_SIG-1:0] out;
    logic [NUM_SIG-1:0] oe;
  } periph_drive_type;

  typedef struct packed {
    logic [NUM_PIN-1:0] out;
    logic [NUM_PIN-1:0] oe;
  } pin_drive_type;

endpackage

// ===== alternate_function_remap_mux.sv
// Purpose: Route peripheral signals to port bits as chosen by the remap fields
// Assumes: Port pins arrive from outside the clock domain; control levels are on i_clk_sys
// Notes: Pin code byte is {port, bit}: 0x0c is port A bit 12, 0x47 is port E bit 7

`timescale 1ns/1ps

module alternate_function_remap_mux #(
  parameter bit SERIAL4_FULL = 1'b0
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Register port
  input wire remap_mux_pkg::reg_req_type i_reg_req,
  output logic [31:0] o_reg_rdata,
  // Peripheral side
  input wire remap_mux_pkg::periph_drive_type i_periph,
  output logic [remap_mux_pkg::NUM_SIG-1:0] o_periph_in,
  input wire logic i_lowspeed_internal_rc,
  // Pin side
  input wire logic [remap_mux_pkg::NUM_PIN-1:0] i_pin_in,
  output remap_mux_pkg::pin_drive_type o_pin_af,
  output logic [remap_mux_pkg::NUM_PIN-1:0] o_pin_gpio_ok,
  // Oscillator, USB and tamper control
  input wire logic i_lowspeed_xtal_enable,
  input wire logic i_usb_device_ctrl_enable,
  input wire logic i_usb_host_device_ctrl_enable,
  input wire logic i_tamper_rtc_out_sel,
  output logic o_usb_device_ctrl_attach,
  output logic o_usb_host_device_ctrl_attach,
  output logic o_tamper_pin_hw_cfg
);

  // ****************************************
  // Placement tables: columns are the raw field value 0..3
  // ****************************************
  // Undefined codes repeat the default column, or column 2 where code 3 is undefined, so they fall back to defined pins
  localparam logic [0:remap_mux_pkg::NUM_SIG-1][0:3][7:0] MAP = '{
    '{8'h0c, 8'h0c, 8'h0c, 8'h47}, // Timer 1 ext trigger
    '{8'h08, 8'h08, 8'h08, 8'h49},
    '{8'h09, 8'h09, 8'h09, 8'h4b},
    '{8'h0a, 8'h0a, 8'h0a, 8'h4d},
    '{8'h0b, 8'h0b, 8'h0b, 8'h4e},
    '{8'h1c, 8'h06, 8'h1c, 8'h4f}, // Break in
    '{8'h1d, 8'h07, 8'h1d, 8'h48},
    '{8'h1e, 8'h10, 8'h1e, 8'h4a},
    '{8'h1f, 8'h11, 8'h1f, 8'h4c},
    '{8'h00, 8'h0f, 8'h00, 8'h00}, // Timer 2, trigger shares ch1 pin
    '{8'h00, 8'h0f, 8'h00, 8'h00},
    '{8'h01, 8'h13, 8'h01, 8'h01},
    '{8'h02, 8'h1a, 8'h02, 8'h02},
    '{8'h03, 8'h1b, 8'h03, 8'h03},
    '{8'h06, 8'h06, 8'h14, 8'h26}, // Timer 3
    '{8'h07, 8'h07, 8'h15, 8'h27},
    '{8'h10, 8'h10, 8'h10, 8'h28},
    '{8'h11, 8'h11, 8'h11, 8'h29},
    '{8'h03, 8'hfe, 8'h03, 8'h03}, // Timer 5 ch4, 0xfe is the RC clock
    '{8'h00, 8'h00, 8'h00, 8'h00}, // Timer 8 trigger never moves
    '{8'h26, 8'h16, 8'h26, 8'h26},
    '{8'h27, 8'h17, 8'h27, 8'h27},
    '{8'h28, 8'h18, 8'h28, 8'h28},
    '{8'h29, 8'h2d, 8'h29, 8'h29},
    '{8'h06, 8'h19, 8'h06, 8'h06},
    '{8'h07, 8'h0d, 8'h07, 8'h07},
    '{8'h10, 8'h0e, 8'h10, 8'h10},
    '{8'h11, 8'h0f, 8'h11, 8'h11},
    '{8'h02, 8'h02, 8'h39, 8'h39}, // Timer 9
    '{8'h02, 8'h02, 8'h39, 8'h39},
    '{8'h03, 8'h03, 8'h3b, 8'h3b},
    '{8'h04, 8'h04, 8'h3d, 8'h3d},
    '{8'h24, 8'h2e, 8'h3f, 8'h3f},
    '{8'h25, 8'h01, 8'h3e, 8'h3e},
    '{8'h20, 8'h10, 8'h38, 8'h38},
    '{8'h21, 8'h11, 8'h3a, 8'h3a},
    '{8'h22, 8'h12, 8'h3c, 8'h3c},
    '{8'h2a, 8'h1b, 8'h30, 8'h30}, // Timer 10
    '{8'h18, 8'h13, 8'h31, 8'h31},
    '{8'h19, 8'h14, 8'h33, 8'h33},
    '{8'h23, 8'h15, 8'h35, 8'h35},
    '{8'h2b, 8'h2f, 8'h37, 8'h37},
    '{8'h2c, 8'h1a, 8'h42, 8'h42},
    '{8'h0c, 8'h05, 8'h43, 8'h43},
    '{8'h0d, 8'h06, 8'h44, 8'h44},
    '{8'h0e, 8'h07, 8'h45, 8'h45},
    '{8'h08, 8'h08, 8'h0a, 8'h05}, // Serial 1 clock, column is {high, low}
    '{8'h09, 8'h16, 8'h1f, 8'h06},
    '{8'h0a, 8'h17, 8'h08, 8'h07},
    '{8'h0b, 8'h0b, 8'h05, 8'h24},
    '{8'h0c, 8'h0c, 8'h09, 8'h25},
    '{8'h00, 8'h33, 8'h00, 8'h00}, // Serial 2 moves A to D
    '{8'h01, 8'h34, 8'h01, 8'h01},
    '{8'h02, 8'h35, 8'h02, 8'h02},
    '{8'h03, 8'h36, 8'h03, 8'h03},
    '{8'h04, 8'h37, 8'h04, 8'h04},
    '{8'h1a, 8'h2a, 8'h0d, 8'h38}, // Serial 3
    '{8'h1b, 8'h2b, 8'h0e, 8'h39},
    '{8'h1c, 8'h2c, 8'h3a, 8'h3a},
    '{8'h1d, 8'h1d, 8'h3b, 8'h3b},
    '{8'h1e, 8'h1e, 8'h3c, 8'h3c},
    '{8'h12, 8'h06, 8'h12, 8'h06}, // Serial 4 full variant, high bit ignored
    '{8'h10, 8'h05, 8'h10, 8'h05},
    '{8'h11, 8'h15, 8'h11, 8'h15},
    '{8'h13, 8'h07, 8'h13, 8'h07},
    '{8'h14, 8'h0f, 8'h14, 8'h0f},
    '{8'h2c, 8'h14, 8'h48, 8'h48}, // Serials 5 to 8
    '{8'h32, 8'h15, 8'h49, 8'h49},
    '{8'h20, 8'h18, 8'h4a, 8'h4a},
    '{8'h21, 8'h19, 8'h4b, 8'h4b},
    '{8'h22, 8'h06, 8'h4c, 8'h4c},
    '{8'h23, 8'h07, 8'h4d, 8'h4d},
    '{8'h24, 8'h0e, 8'h4e, 8'h4e},
    '{8'h25, 8'h0f, 8'h4f, 8'h4f}
  };

  // Two-signal serial 4 variant: only transmit and receive have pins
  localparam logic [0:4][0:3][7:0] MAP_SER4_NARROW = '{
    '{8'hff, 8'hff, 8'hff, 8'hff},
    '{8'h2a, 8'h10, 8'h40, 8'h40},
    '{8'h2b, 8'h11, 8'h41, 8'h41},
    '{8'hff, 8'hff, 8'hff, 8'hff},
    '{8'hff, 8'hff, 8'hff, 8'hff}
  };

  // ****************************************
  // Select decoding
  // ****************************************
  // Table column for one signal, from the two remap registers
  // Single-bit fields give column 0 or 1 only
  function automatic logic [1:0] col_of(input int s, input logic [31:0] r1, input logic [31:0] r2);
    if (s < remap_mux_pkg::B_TIM2) begin
      col_of = r1[remap_mux_pkg::F_ADV_TIMER1 +: 2];
    end else if (s < remap_mux_pkg::B_TIM2 + 3) begin
      col_of = {1'b0, r1[remap_mux_pkg::F_TIMER2]};
    end else if (s < remap_mux_pkg::B_TIM3) begin
      col_of = {1'b0, r1[remap_mux_pkg::F_TIMER2 + 1]};
    end else if (s < remap_mux_pkg::B_TIM5) begin
      col_of = r1[remap_mux_pkg::F_TIMER3 +: 2];
    end else if (s < remap_mux_pkg::B_TIM8) begin
      col_of = {1'b0, r1[remap_mux_pkg::F_TIMER5_CH4]};
    end else if (s < remap_mux_pkg::B_TIM9) begin
      col_of = {1'b0, r2[remap_mux_pkg::F_ADV_TIMER8]};
    end else if (s < remap_mux_pkg::B_TIM10) begin
      col_of = r2[remap_mux_pkg::F_ADV_TIMER9 +: 2];
    end else if (s < remap_mux_pkg::B_SER1) begin
      col_of = r2[remap_mux_pkg::F_ADV_TIMER10 +: 2];
    end else if (s < remap_mux_pkg::B_SER2) begin
      col_of = {r2[remap_mux_pkg::F_SERIAL1_HIGH], r1[remap_mux_pkg::F_SERIAL1_LOW]};
    end else if (s < remap_mux_pkg::B_SER3) begin
      col_of = {1'b0, r1[remap_mux_pkg::F_SERIAL2]};
    end else if (s < remap_mux_pkg::B_SER4) begin
      col_of = r1[remap_mux_pkg::F_SERIAL3 +: 2];
    end else if (s < remap_mux_pkg::B_SER5) begin
      col_of = r2[remap_mux_pkg::F_SERIAL4 +: 2];
    end else begin
      // Serials 5..8 take consecutive two-bit fields
      col_of = r2[(remap_mux_pkg::F_SERIAL5 + ((s - remap_mux_pkg::B_SER5) / 2) * 2) +: 2];
    end
  endfunction

  // Pin code for one signal, honouring the serial 4 variant
  function automatic logic [7:0] code_of(input int s, input logic [1:0] col);
    if (!SERIAL4_FULL && s >= remap_mux_pkg::B_SER4 && s < remap_mux_pkg::B_SER5) begin
      code_of = MAP_SER4_NARROW[s - remap_mux_pkg::B_SER4][col];
    end else begin
      code_of = MAP[s][col];
    end
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  // Stored selections; masked bits only
  logic [31:0] remap_one_r;
  logic [31:0] remap_one_nxt;
  logic [31:0] remap_two_r;
  logic [31:0] remap_two_nxt;

  // One-cycle read data stage
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Read-only status from live flags
  logic [31:0] status_c;

  // Own state seen by software
  assign status_c = {27'h0000000, o_tamper_pin_hw_cfg, o_usb_host_device_ctrl_attach,
                     o_usb_device_ctrl_attach, remap_one_r[remap_mux_pkg::F_MAIN_XTAL],
                     i_lowspeed_xtal_enable};

  // Writes store only the defined field bits; read data lives one cycle only
  always_comb begin
    remap_one_nxt = remap_one_r;
    remap_two_nxt = remap_two_r;
    rdata_nxt = 32'h0000_0000;
    if (i_reg_req.wr && i_reg_req.addr == remap_mux_pkg::OFS_REMAP_ONE) begin
      remap_one_nxt = i_reg_req.wdata & remap_mux_pkg::MASK_REMAP_ONE;
    end
    if (i_reg_req.wr && i_reg_req.addr == remap_mux_pkg::OFS_REMAP_TWO) begin
      remap_two_nxt = i_reg_req.wdata & remap_mux_pkg::MASK_REMAP_TWO;
    end
    if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        remap_mux_pkg::OFS_REMAP_ONE: rdata_nxt = remap_one_r;
        remap_mux_pkg::OFS_REMAP_TWO: rdata_nxt = remap_two_r;
        remap_mux_pkg::OFS_STATUS: rdata_nxt = status_c;
        default: rdata_nxt = 32'h0000_0000; // Unmapped reads return zero
      endcase
    end
  end

  // Reset returns every placement to default
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      remap_one_r <= remap_mux_pkg::RST_REMAP_ONE;
      remap_two_r <= remap_mux_pkg::RST_REMAP_TWO;
      rdata_r <= 32'h0000_0000;
    end else begin
      remap_one_r <= remap_one_nxt;
      remap_two_r <= remap_two_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Read data straight from the flip-flop
  assign o_reg_rdata = rdata_r;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Port pin levels, asynchronous
  logic [remap_mux_pkg::NUM_PIN-1:0] pin_meta_r;
  logic [remap_mux_pkg::NUM_PIN-1:0] pin_sync_r;

  // Internal RC clock, asynchronous
  logic lsi_meta_r;
  logic lsi_sync_r;

  // Two stages; only the second stage feeds any logic
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      lsi_meta_r <= 1'b0;
      lsi_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= i_pin_in;
      pin_sync_r <= pin_meta_r;
      lsi_meta_r <= i_lowspeed_internal_rc;
      lsi_sync_r <= lsi_meta_r;
    end
  end

  // ****************************************
  // Oscillator pin ownership
  // ****************************************
  logic [remap_mux_pkg::NUM_PIN-1:0] pin_usable_c;

  // Crystal pins stay off the port fabric while the oscillator owns them
  always_comb begin
    pin_usable_c = '1;
    if (i_lowspeed_xtal_enable) begin
      pin_usable_c[remap_mux_pkg::PIN_LS_XTAL_A] = 1'b0;
      pin_usable_c[remap_mux_pkg::PIN_LS_XTAL_B] = 1'b0;
    end
    if (!remap_one_r[remap_mux_pkg::F_MAIN_XTAL]) begin
      pin_usable_c[remap_mux_pkg::PIN_MAIN_XTAL_A] = 1'b0;
      pin_usable_c[remap_mux_pkg::PIN_MAIN_XTAL_B] = 1'b0;
    end
  end

  // ****************************************
  // Routing
  // ****************************************
  // Registered routing results
  logic [remap_mux_pkg::NUM_SIG-1:0] sig_in_r;
  logic [remap_mux_pkg::NUM_SIG-1:0] sig_in_nxt;
  logic [remap_mux_pkg::NUM_PIN-1:0] af_out_r;
  logic [remap_mux_pkg::NUM_PIN-1:0] af_out_nxt;
  logic [remap_mux_pkg::NUM_PIN-1:0] af_oe_r;
  logic [remap_mux_pkg::NUM_PIN-1:0] af_oe_nxt;
  logic [remap_mux_pkg::NUM_PIN-1:0] gpio_ok_r;

  // Pin code under decode, scratch
  logic [7:0] code_c;

  // Signals sharing one pin merge by OR; a pin of the oscillator reads and drives nothing
  always_comb begin
    code_c = remap_mux_pkg::PIN_NONE;
    sig_in_nxt = '0;
    af_out_nxt = '0;
    af_oe_nxt = '0;
    for (int s = 0; s < remap_mux_pkg::NUM_SIG; s++) begin
      code_c = code_of(s, col_of(s, remap_one_r, remap_two_r));
      // Codes past the pin limit touch no pin
      if (code_c == remap_mux_pkg::PIN_LSI) begin
        sig_in_nxt[s] = lsi_sync_r;
      end else if (code_c < remap_mux_pkg::PIN_LIMIT) begin
        if (pin_usable_c[code_c[6:0]]) begin
          sig_in_nxt[s] = pin_sync_r[code_c[6:0]];
          af_out_nxt[code_c[6:0]] = af_out_nxt[code_c[6:0]] | (i_periph.out[s] & i_periph.oe[s]);
          af_oe_nxt[code_c[6:0]] = af_oe_nxt[code_c[6:0]] | i_periph.oe[s];
        end
      end
    end
  end

  // Registered so that data outputs come straight from flip-flops
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sig_in_r <= '0;
      af_out_r <= '0;
      af_oe_r <= '0;
      gpio_ok_r <= '0;
    end else begin
      sig_in_r <= sig_in_nxt;
      af_out_r <= af_out_nxt;
      af_oe_r <= af_oe_nxt;
      gpio_ok_r <= pin_usable_c;
    end
  end

  assign o_periph_in = sig_in_r;
  assign o_pin_af.out = af_out_r;
  assign o_pin_af.oe = af_oe_r;
  assign o_pin_gpio_ok = gpio_ok_r;

  // ****************************************
  // Automatic pin hand-over
  // ****************************************
  // Enables, one cycle behind
  logic usb_device_ctrl_r;
  logic usb_host_device_ctrl_r;
  logic tamper_r;

  // No software port setup needed; the enable alone claims the pins
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      usb_device_ctrl_r <= 1'b0;
      usb_host_device_ctrl_r <= 1'b0;
      tamper_r <= 1'b0;
    end else begin
      usb_device_ctrl_r <= i_usb_device_ctrl_enable;
      usb_host_device_ctrl_r <= i_usb_host_device_ctrl_enable;
      tamper_r <= i_tamper_rtc_out_sel;
    end
  end

  assign o_usb_device_ctrl_attach = usb_device_ctrl_r;
  assign o_usb_host_device_ctrl_attach = usb_host_device_ctrl_r;
  assign o_tamper_pin_hw_cfg = tamper_r;

endmodule // alternate_function_remap_mux

// ===== remap_mux_checker.sv
// Purpose: Concurrent checks on the remap mux ports
// Assumes: One clock domain, synchronous active-high reset
// Notes: Attached by bind below the module

`timescale 1ns/1ps

module remap_mux_checker (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Register and peripheral side
  input wire remap_mux_pkg::reg_req_type i_reg_req,
  input wire logic [31:0] o_reg_rdata,
  input wire remap_mux_pkg::periph_drive_type i_periph,
  input wire logic [remap_mux_pkg::NUM_SIG-1:0] o_periph_in,
  // Pin side
  input wire remap_mux_pkg::pin_drive_type o_pin_af,
  input wire logic [remap_mux_pkg::NUM_PIN-1:0] o_pin_gpio_ok,
  // Oscillator, USB and tamper
  input wire logic i_lowspeed_xtal_enable,
  input wire logic i_usb_device_ctrl_enable,
  input wire logic i_tamper_rtc_out_sel,
  input wire logic o_usb_device_ctrl_attach,
  input wire logic o_tamper_pin_hw_cfg
);
  logic main_r;
  logic main_nxt;

  // Shadow of the main crystal bit, so ownership of its pins can be predicted
  always_comb begin
    main_nxt = main_r;
    if (i_reg_req.wr && i_reg_req.addr == remap_mux_pkg::OFS_REMAP_ONE) begin
      main_nxt = i_reg_req.wdata[remap_mux_pkg::F_MAIN_XTAL];
    end
  end

  // Register the shadow
  always_ff @(posedge i_clk_sys) begin
    main_r <= i_srst ? 1'b0 : main_nxt;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // ****************************************
  // Properties
  // ****************************************
  reset_quiet_a: assert property (disable iff (1'b0) i_srst |=>
    (o_pin_gpio_ok == '0 && o_pin_af == '0 && o_periph_in == '0 && o_reg_rdata == 32'h0))
    else $error("Outputs not quiet under reset");
  xtal_owned_a: assert property (i_lowspeed_xtal_enable |=> o_pin_gpio_ok[47:46] == 2'b00)
    else $error("Low-speed crystal pins left usable");
  xtal_free_a: assert property (!i_srst && !i_lowspeed_xtal_enable |=> o_pin_gpio_ok[47:46] == 2'b11)
    else $error("Low-speed crystal pins not released");
  main_pins_a: assert property (1'b1 |=> o_pin_gpio_ok[49:48] == {2{$past(main_r)}})
    else $error("Main crystal pin ownership wrong");
  usb_attach_a: assert property ($rose(i_usb_device_ctrl_enable) |=> o_usb_device_ctrl_attach)
    else $error("USB pins not attached after enable");
  tamper_cfg_a: assert property (1'b1 |=> o_tamper_pin_hw_cfg == $past(i_tamper_rtc_out_sel))
    else $error("Tamper pin setup not following selection");
  trig_share_a: assert property (o_periph_in[10] == o_periph_in[9])
    else $error("Timer 2 trigger and channel 1 differ");
  trig9_share_a: assert property (o_periph_in[29] == o_periph_in[28])
    else $error("Timer 9 trigger and channel 1 differ");
  trig8_stay_a: assert property (i_periph.oe[19] && i_periph.out[19] |=> o_pin_af.oe[0] && o_pin_af.out[0])
    else $error("Timer 8 trigger left its pin");
endmodule // remap_mux_checker

bind alternate_function_remap_mux remap_mux_checker i_remap_mux_checker (
  .i_clk_sys, .i_srst, .i_reg_req, .o_reg_rdata, .i_periph, .o_periph_in, .o_pin_af,
  .o_pin_gpio_ok, .i_lowspeed_xtal_enable, .i_usb_device_ctrl_enable, .i_tamper_rtc_out_sel,
  .o_usb_device_ctrl_attach, .o_tamper_pin_hw_cfg
);

// ===== port_pin_model.sv
// Purpose: Board-side model of the port pins
// Assumes: Alternate outputs are push-pull, inputs floating or pulled up
// Notes: An undriven pin shows the board level chosen by the bench

`timescale 1ns/1ps

module port_pin_model (
  // Board level of pins nobody drives
  input wire logic [79:0] i_board_level,
  // Drive from the mux
  input wire remap_mux_pkg::pin_drive_type i_pin_af,
  // Resolved levels back into the mux
  output logic [79:0] o_pin_level
);
  // Push-pull alternate outputs win; inputs read the board
  assign o_pin_level = (i_pin_af.oe & i_pin_af.out) | (~i_pin_af.oe & i_board_level);
endmodule // port_pin_model

// ===== testbench.sv
// Purpose: Self-checking bench for the remap mux
// Assumes: 25 MHz clock, reset held six cycles
// Notes: Only one peripheral signal is driven at a time, so at most one pin may light

`timescale 1ns/1ps

module testbench;
  logic i_clk_sys;
  logic i_srst = 1'b1;
  remap_mux_pkg::reg_req_type req = '0;
  remap_mux_pkg::periph_drive_type periph = '0;
  remap_mux_pkg::pin_drive_type af;
  remap_mux_pkg::pin_drive_type af_full;
  logic [31:0] rdata;
  logic [73:0] periph_in;
  logic [79:0] board = '0;
  logic [79:0] pin_lvl;
  logic [79:0] gpio_ok;
  logic rc = 1'b0;
  logic xtal_en = 1'b0;
  logic usb_dev = 1'b0;
  logic usb_hd = 1'b0;
  logic tamper = 1'b0;
  logic [2:0] attach;
  int fails = 0;
  int num_checks = 0;

  alternate_function_remap_mux i_alternate_function_remap_mux (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_req(req), .o_reg_rdata(rdata),
    .i_periph(periph), .o_periph_in(periph_in), .i_lowspeed_internal_rc(rc),
    .i_pin_in(pin_lvl), .o_pin_af(af), .o_pin_gpio_ok(gpio_ok),
    .i_lowspeed_xtal_enable(xtal_en), .i_usb_device_ctrl_enable(usb_dev),
    .i_usb_host_device_ctrl_enable(usb_hd), .i_tamper_rtc_out_sel(tamper),
    .o_usb_device_ctrl_attach(attach[0]), .o_usb_host_device_ctrl_attach(attach[1]),
    .o_tamper_pin_hw_cfg(attach[2])
  );

  port_pin_model i_port_pin_model (.i_board_level(board), .i_pin_af(af), .o_pin_level(pin_lvl));

  // Full serial 4 variant; only its pin drive is watched
  alternate_function_remap_mux #(.SERIAL4_FULL(1'b1)) i_alternate_function_remap_mux_full (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_req(req), .o_reg_rdata(),
    .i_periph(periph), .o_periph_in(), .i_lowspeed_internal_rc(rc),
    .i_pin_in(pin_lvl), .o_pin_af(af_full), .o_pin_gpio_ok(),
    .i_lowspeed_xtal_enable(xtal_en), .i_usb_device_ctrl_enable(usb_dev),
    .i_usb_host_device_ctrl_enable(usb_hd), .i_tamper_rtc_out_sel(tamper),
    .o_usb_device_ctrl_attach(), .o_usb_host_device_ctrl_attach(), .o_tamper_pin_hw_cfg()
  );

  // Clock at 40 ns
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Load both remap registers, drive one signal, expect exactly one pin (none if pin > 79)
  task automatic route(input logic [31:0] r1, input logic [31:0] r2, input int sig, input int pin);
    logic [79:0] e;
    e = (pin > 79) ? 80'h0 : (80'h1 << pin);
    reg_wr(remap_mux_pkg::OFS_REMAP_ONE, r1);
    reg_wr(remap_mux_pkg::OFS_REMAP_TWO, r2);
    @(posedge i_clk_sys);
    periph.oe[sig] <= 1'b1;
    periph.out[sig] <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1 chk("pin enable", af.oe, e);
    chk("pin level", af.out, e);
    @(posedge i_clk_sys);
    periph <= '0;
  endtask

  // Walk all four codes of a two-bit field
  task automatic codes(input logic two, input int sh, input int sig, input logic [31:0] b1,
                       input int p0, input int p1, input int p2, input int p3);
    int p[4];
    p = '{p0, p1, p2, p3};
    for (int c = 0; c < 4; c++) begin
      route(two ? b1 : b1 | (32'(c) << sh), two ? (32'(c) << sh) : 32'h0, sig, p[c]);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults();
    logic [31:0] d;
    reg_rd(remap_mux_pkg::OFS_REMAP_ONE, d);
    chk("reg one at reset", d, 80'h0);
    reg_rd(remap_mux_pkg::OFS_REMAP_TWO, d);
    chk("reg two at reset", d, 80'h0);
    route(0, 0, 1, 8'h08);
    $display("defaults done");
  endtask

  task automatic t_timers();
    codes(0, 6, 5, 0, 8'h1c, 8'h06, 8'h1c, 8'h4f);
    codes(0, 8, 11, 0, 8'h01, 8'h13, 8'h01, 8'h13);
    codes(0, 8, 12, 0, 8'h02, 8'h02, 8'h1a, 8'h1a);
    codes(0, 10, 14, 0, 8'h06, 8'h06, 8'h14, 8'h26);
    route(0, 0, 25, 8'h07);
    route(0, 32'h4, 25, 8'h0d);
    route(0, 32'h4, 19, 8'h00);
    codes(1, 3, 32, 0, 8'h24, 8'h2e, 8'h3f, 8'h3f);
    codes(1, 5, 38, 32'h8000, 8'h18, 8'h13, 8'h31, 8'h31);
    $display("timers done");
  endtask

  task automatic t_serials();
    route(0, 0, 47, 8'h09);
    route(32'h4, 0, 47, 8'h16);
    route(0, 32'h0400_0000, 47, 8'h1f);
    route(32'h4, 32'h0400_0000, 47, 8'h06);
    route(32'h8, 0, 53, 8'h35);
    route(32'h8, 0, 55, 8'h37);
    codes(0, 4, 56, 0, 8'h1a, 8'h2a, 8'h0d, 8'h38);
    codes(1, 16, 62, 0, 8'h2a, 8'h10, 8'h40, 8'h40);
    codes(1, 18, 66, 0, 8'h2c, 8'h14, 8'h48, 8'h48);
    codes(1, 20, 68, 0, 8'h20, 8'h18, 8'h4a, 8'h4a);
    codes(1, 22, 70, 0, 8'h22, 8'h06, 8'h4c, 8'h4c);
    codes(1, 24, 72, 0, 8'h24, 8'h0e, 8'h4e, 8'h4e);
    $display("serials done");
  endtask

  // Full variant ignores the high bit; its drive still stands just after route lets go
  task automatic t_ser4_full();
    for (int c = 0; c < 4; c++) begin
      route(0, 32'(c) << 16, 61, 8'hff);
      #1 chk("full serial 4 clock", af_full.oe, 80'h1 << (c[0] ? 8'h06 : 8'h12));
    end
    $display("serial 4 full done");
  endtask

  // Crystal pins: owned pins drive nothing even when a timer maps onto them
  task automatic t_xtal();
    logic [31:0] d;
    xtal_en <= 1'b1;
    route(0, 32'h8, 32, 8'hff);
    reg_rd(remap_mux_pkg::OFS_STATUS, d);
    chk("status crystal bit", d[0], 80'h1);
    chk("crystal pins owned", gpio_ok[49:46], 80'h0);
    @(posedge i_clk_sys);
    xtal_en <= 1'b0;
    reg_wr(remap_mux_pkg::OFS_REMAP_ONE, 32'h8000);
    repeat (2) @(posedge i_clk_sys);
    #1 chk("crystal pins free", gpio_ok[49:46], 80'hf);
    $display("crystal done");
  endtask

  // Input path: pin levels and the internal RC reach the peripherals
  task automatic t_inputs();
    reg_wr(remap_mux_pkg::OFS_REMAP_ONE, 32'h0300);
    board <= 80'h1 << 15;
    repeat (4) @(posedge i_clk_sys);
    #1 chk("timer 2 trigger and ch1", periph_in[10:9], 80'h3);
    reg_wr(remap_mux_pkg::OFS_REMAP_ONE, 32'h0001_0000);
    board <= 80'h8;
    rc <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1 chk("ch4 from RC high", periph_in[18], 80'h1);
    @(posedge i_clk_sys);
    rc <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    #1 chk("ch4 from RC low", periph_in[18], 80'h0);
    reg_wr(remap_mux_pkg::OFS_REMAP_ONE, 32'h0);
    repeat (4) @(posedge i_clk_sys);
    #1 chk("ch4 from pin", periph_in[18], 80'h1);
    @(posedge i_clk_sys);
    board <= '0;
    $display("inputs done");
  endtask

  // Masks, an unmapped address, USB and tamper flags
  task automatic t_regs_misc();
    logic [31:0] d;
    reg_wr(remap_mux_pkg::OFS_REMAP_ONE, '1);
    reg_rd(remap_mux_pkg::OFS_REMAP_ONE, d);
    chk("reg one mask", d, remap_mux_pkg::MASK_REMAP_ONE);
    reg_wr(remap_mux_pkg::OFS_REMAP_TWO, '1);
    reg_rd(remap_mux_pkg::OFS_REMAP_TWO, d);
    chk("reg two mask", d, remap_mux_pkg::MASK_REMAP_TWO);
    reg_wr(8'h10, '1);
    reg_rd(8'h10, d);
    chk("unmapped read", d, 80'h0);
    @(posedge i_clk_sys);
    usb_dev <= 1'b1;
    usb_hd <= 1'b1;
    tamper <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1 chk("attach flags", attach, 80'h7);
    reg_rd(remap_mux_pkg::OFS_STATUS, d);
    chk("status flags", d, 80'h1e);
    @(posedge i_clk_sys);
    usb_dev <= 1'b0;
    usb_hd <= 1'b0;
    tamper <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1 chk("attach flags off", attach, 80'h0);
    $display("registers done");
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    t_defaults();
    t_timers();
    t_serials();
    t_ser4_full();
    t_xtal();
    t_inputs();
    t_regs_misc();
    results();
  end

  // Watchdog: the tests take about 570 cycles
  initial begin
    #800000;
    fails++;
    results();
  end
endmodule // testbench
